// *** shared/dog_pkg.sv ***
/*
 Constants for the two octal GPIO / address ports: register offsets,
 reset values, widths and operating mode codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dog_pkg;

  localparam int DOG_PORT_W = 8;
  localparam int DOG_ADDR_W = 16;

  // Register indices; some are odd, so the byte address is four times the index
  localparam logic [15:0] DOG_IDX_P1_DIR = 16'hffc0;
  localparam logic [15:0] DOG_IDX_P2_DIR = 16'hffc1;
  localparam logic [15:0] DOG_IDX_P1_DAT = 16'hffc2;
  localparam logic [15:0] DOG_IDX_P2_DAT = 16'hffc3;
  localparam logic [15:0] DOG_IDX_P2_PUP = 16'hffd8;
  localparam logic [15:0] DOG_IDX_CTRL = 16'hffe0;

  localparam logic [7:0] DOG_DIR_RST = 8'h00;
  localparam logic [7:0] DOG_DAT_RST = 8'h00;
  localparam logic [7:0] DOG_PUP_RST = 8'h00;
  localparam logic [7:0] DOG_DIR_READ = 8'hff;

  // Control register fields
  localparam int DOG_CTRL_MODE_LSB = 0;
  localparam int DOG_CTRL_SWSTBY_BIT = 2;
  localparam logic [1:0] DOG_MODE_RST = 2'h2;

  localparam logic [1:0] DOG_MODE_EXP = 2'h1;

  localparam logic [1:0] DOG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DOG_RESP_SLVERR = 2'h2;

  localparam int DOG_SYNC_STAGES = 2;

endpackage : dog_pkg

// *** rtl/dog_sync.sv ***
/*
 Two-flip-flop synchroniser for a bus of pin inputs.
 Assumes inputs are asynchronous to clk; first stage read only by second.
*/
`timescale 1ns/10ps
module dog_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : dog_sync

// *** rtl/dog_ports.sv ***
/*
 Two octal GPIO ports with address-line multiplexing and port 2 pull-ups,
 behind an AXI4-Lite register slave.
 Assumes: one clock, async active-low reset, hardware standby as an
 active-high input that clears state like reset except the mode; software standby is a
 control register bit that freezes the pin drive values.
*/
// Our own choice: the AXI4-Lite slave port.
// Overview of operation
// RL1: mode 1: dir 1 drives address, else input
// RL2: modes 2,3: dir 1 drives data bit
// RL3: port1 carries A7..A0, port2 A15..A8
// RL4: direction registers write-only, read all ones
// RL5: direction clears on reset, hardware standby
// RL6: software standby keeps output pins driven
// RL7: data read: stored bit if output, else pin
// RL8: data registers RW, clear on reset/standby
// RL9: after reset in mode 1, all inputs
// RL10: pull-up on only if control 1, dir 0
// RL11: one pull-up control bit per pin
// RL12: pull-up control RW, clears on reset/standby
// RL13: pull-ups off in reset/hw standby, kept otherwise
// RL14: writes reach pin outputs next clock edge; here they reach them one edge after the register update
`timescale 1ns/10ps
module dog_ports
  import dog_pkg::*;
#(
  parameter int PORT_W = DOG_PORT_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hw_standby,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DOG_ADDR_W-1:0] cpu_addr,
  input wire logic [PORT_W-1:0] port1_in,
  output logic [PORT_W-1:0] port1_out,
  output logic [PORT_W-1:0] port1_oe_n,
  input wire logic [PORT_W-1:0] port2_in,
  output logic [PORT_W-1:0] port2_out,
  output logic [PORT_W-1:0] port2_oe_n,
  output logic [PORT_W-1:0] port2_pullup_on,
  output logic [1:0] mode_out,
  output logic sw_standby_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [PORT_W-1:0] port1_direction_q, port1_direction_d;
  logic [PORT_W-1:0] port2_direction_q, port2_direction_d;
  logic [PORT_W-1:0] port1_output_data_q, port1_output_data_d;
  logic [PORT_W-1:0] port2_output_data_q, port2_output_data_d;
  logic [PORT_W-1:0] port2_pullup_enable_q, port2_pullup_enable_d;
  logic [1:0] mode_q, mode_d;
  logic swstby_q, swstby_d;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave state

  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [15:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic w_strb0_q, w_strb0_d;
  logic bvalid_q, bvalid_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin output state

  logic [PORT_W-1:0] p1_out_q, p1_out_d, p1_oen_q, p1_oen_d;
  logic [PORT_W-1:0] p2_out_q, p2_out_d, p2_oen_q, p2_oen_d;
  logic [PORT_W-1:0] pup_q, pup_d;

  logic [PORT_W-1:0] p1_pin, p2_pin;
  logic do_write;
  logic [15:0] rd_addr;

  dog_sync #(.WIDTH(2 * PORT_W)) u_pin_sync (
    .clk(sys_clk),
    .resetn(resetn),
    .async_in({port2_in, port1_in}),
    .sync_out({p2_pin, p1_pin})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus next-state

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb0_d = w_strb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = 1'b0;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_addr = s_axi_araddr[17:2];
    do_write = 1'b0;
    // Address and data accepted in either order
    if (s_axi_awvalid && !aw_held_q && !bvalid_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && !w_held_q && !bvalid_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb0_d = s_axi_wstrb[0];
    end
    if (aw_held_q && w_held_q) begin
      do_write = 1'b1;
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = DOG_RESP_OKAY;
      unique case (aw_addr_q)
        DOG_IDX_P1_DIR, DOG_IDX_P2_DIR, DOG_IDX_P1_DAT, DOG_IDX_P2_DAT,
        DOG_IDX_P2_PUP, DOG_IDX_CTRL: bresp_d = DOG_RESP_OKAY;
        default: bresp_d = DOG_RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !arready_q && !rvalid_q) begin
      arready_d = 1'b1;
      rvalid_d = 1'b1;
      rresp_d = DOG_RESP_OKAY;
      rdata_d = '0;
      unique case (rd_addr)
        DOG_IDX_P1_DIR, DOG_IDX_P2_DIR: rdata_d[7:0] = DOG_DIR_READ; // see RL4
        // Output pins read the latch, inputs the synchronised pin
        DOG_IDX_P1_DAT: rdata_d[7:0] = (port1_direction_q & port1_output_data_q)
                                      | (~port1_direction_q & p1_pin); // see RL7
        DOG_IDX_P2_DAT: rdata_d[7:0] = (port2_direction_q & port2_output_data_q)
                                      | (~port2_direction_q & p2_pin); // see RL7
        DOG_IDX_P2_PUP: rdata_d[7:0] = port2_pullup_enable_q; // see RL12
        DOG_IDX_CTRL: rdata_d[2:0] = {swstby_q, mode_q};
        default: begin
          rresp_d = DOG_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = ~aw_held_d & ~bvalid_d;
    wready_d = ~w_held_d & ~bvalid_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next-state

  always_comb begin
    port1_direction_d = port1_direction_q;
    port2_direction_d = port2_direction_q;
    port1_output_data_d = port1_output_data_q;
    port2_output_data_d = port2_output_data_q;
    port2_pullup_enable_d = port2_pullup_enable_q;
    mode_d = mode_q;
    swstby_d = swstby_q;
    // Software standby blocks nothing here; state simply holds
    if (do_write && w_strb0_q) begin
      unique case (aw_addr_q)
        DOG_IDX_P1_DIR: port1_direction_d = w_data_q[7:0];
        DOG_IDX_P2_DIR: port2_direction_d = w_data_q[7:0];
        DOG_IDX_P1_DAT: port1_output_data_d = w_data_q[7:0]; // see RL8
        DOG_IDX_P2_DAT: port2_output_data_d = w_data_q[7:0]; // see RL8
        DOG_IDX_P2_PUP: port2_pullup_enable_d = w_data_q[7:0]; // see RL11
        DOG_IDX_CTRL: begin
          mode_d = w_data_q[DOG_CTRL_MODE_LSB +: 2];
          swstby_d = w_data_q[DOG_CTRL_SWSTBY_BIT];
        end
        default: mode_d = mode_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive next-state, one cycle after the register write

  always_comb begin
    // Per pin: dir 1 outputs address in mode 1, data otherwise
    p1_oen_d = ~port1_direction_q; // see RL1 RL2 RL9
    p2_oen_d = ~port2_direction_q; // see RL1 RL2 RL9
    if (mode_q == DOG_MODE_EXP) begin
      p1_out_d = cpu_addr[7:0]; // see RL3
      p2_out_d = cpu_addr[15:8]; // see RL3
    end else begin
      p1_out_d = port1_output_data_q;
      p2_out_d = port2_output_data_q;
    end
    pup_d = port2_pullup_enable_q & ~port2_direction_q; // see RL10 RL14
    // Standby leaves driven pins untouched
    if (swstby_q) begin
      p1_out_d = p1_out_q; // see RL6
      p2_out_d = p2_out_q; // see RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers: reset clears all; hardware standby clears all but the mode

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port1_direction_q <= DOG_DIR_RST; // see RL5
      port2_direction_q <= DOG_DIR_RST;
      port1_output_data_q <= DOG_DAT_RST;
      port2_output_data_q <= DOG_DAT_RST;
      port2_pullup_enable_q <= DOG_PUP_RST;
      mode_q <= DOG_MODE_RST;
      swstby_q <= 1'b0;
      p1_out_q <= '0;
      p2_out_q <= '0;
      p1_oen_q <= '1;
      p2_oen_q <= '1;
      pup_q <= '0; // see RL13
    end else if (hw_standby) begin
      port1_direction_q <= DOG_DIR_RST; // see RL5
      port2_direction_q <= DOG_DIR_RST;
      port1_output_data_q <= DOG_DAT_RST; // see RL8
      port2_output_data_q <= DOG_DAT_RST;
      port2_pullup_enable_q <= DOG_PUP_RST; // see RL12
      swstby_q <= 1'b0;
      mode_q <= mode_d;
      p1_out_q <= '0;
      p2_out_q <= '0;
      p1_oen_q <= '1;
      p2_oen_q <= '1;
      pup_q <= '0; // see RL13
    end else begin
      port1_direction_q <= port1_direction_d;
      port2_direction_q <= port2_direction_d;
      port1_output_data_q <= port1_output_data_d;
      port2_output_data_q <= port2_output_data_d;
      port2_pullup_enable_q <= port2_pullup_enable_d;
      mode_q <= mode_d;
      swstby_q <= swstby_d;
      p1_out_q <= p1_out_d;
      p2_out_q <= p2_out_d;
      p1_oen_q <= p1_oen_d;
      p2_oen_q <= p2_oen_d;
      pup_q <= pup_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bresp_q <= DOG_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= DOG_RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb0_q <= w_strb0_d;
      bvalid_q <= bvalid_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign port1_out = p1_out_q;
  assign port1_oe_n = p1_oen_q;
  assign port2_out = p2_out_q;
  assign port2_oe_n = p2_oen_q;
  assign port2_pullup_on = pup_q;
  assign mode_out = mode_q;
  assign sw_standby_out = swstby_q;

endmodule : dog_ports

// *** testbench/dog_ports_properties.sv ***
/*
 Checker on the pins and bus of dog_ports.
 Assumes one clock sys_clk and the active-low resetn of dog_ports.
*/
`timescale 1ns/10ps
module dog_ports_chk
  import dog_pkg::*;
#(
  parameter int PORT_W = DOG_PORT_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic hw_standby,
  input wire logic [DOG_ADDR_W-1:0] cpu_addr,
  input wire logic [PORT_W-1:0] port1_out,
  input wire logic [PORT_W-1:0] port1_oe_n,
  input wire logic [PORT_W-1:0] port2_out,
  input wire logic [PORT_W-1:0] port2_oe_n,
  input wire logic [PORT_W-1:0] port2_pullup_on,
  input wire logic [1:0] mode_out,
  input wire logic sw_standby_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Both mode samples steady, so a mode switch edge is not judged
  chk_p1_addr_out: assert property (
    mode_out == DOG_MODE_EXP && $past(mode_out) == DOG_MODE_EXP && !sw_standby_out
    && !$past(sw_standby_out) |-> ((port1_out ^ $past(cpu_addr[7:0])) & ~port1_oe_n) == '0)
    else $error("port1 address line mismatch");
  chk_p2_addr_out: assert property (
    mode_out == DOG_MODE_EXP && $past(mode_out) == DOG_MODE_EXP && !sw_standby_out
    && !$past(sw_standby_out) |-> ((port2_out ^ $past(cpu_addr[15:8])) & ~port2_oe_n) == '0)
    else $error("port2 address line mismatch");
  chk_sw_hold_out: assert property (sw_standby_out && $past(sw_standby_out)
    |-> $stable(port1_out) && $stable(port2_out)) else $error("output moved in standby");
  chk_hw_clear_all: assert property (hw_standby |=> port1_oe_n == '1
    && port2_oe_n == '1 && port2_pullup_on == '0) else $error("hardware standby not cleared");
  chk_pullup_input: assert property ((port2_pullup_on & ~port2_oe_n) == '0)
    else $error("pull-up on a driven pin");
  chk_rd_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_rvalid && s_axi_arready) else $error("read not answered next cycle");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  cover property (mode_out == DOG_MODE_EXP && port1_oe_n != '1);
  cover property (sw_standby_out && port1_oe_n != '1);
  cover property (s_axi_bvalid && s_axi_bresp == DOG_RESP_SLVERR);
endmodule : dog_ports_chk

bind dog_ports dog_ports_chk #(.PORT_W(PORT_W)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .hw_standby(hw_standby), .cpu_addr(cpu_addr), .port1_out(port1_out),
  .port1_oe_n(port1_oe_n), .port2_out(port2_out), .port2_oe_n(port2_oe_n),
  .port2_pullup_on(port2_pullup_on), .mode_out(mode_out), .sw_standby_out(sw_standby_out),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

// *** testbench/dog_pin_model.sv ***
/*
 Board model: pin levels seen by both ports.
 Assumes outputs with active-low enables; undriven, unpulled pins float.
*/
`timescale 1ns/10ps
module dog_pin_model (
  input wire logic sys_clk,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe_n,
  input wire logic [7:0] p2_pu,
  input wire logic [7:0] ext1,
  input wire logic [7:0] ext2,
  input wire logic [7:0] ext2_en,
  output logic [7:0] p1_in,
  output logic [7:0] p2_in
);
  // Floating lines change every cycle so a stale value never passes
  logic [7:0] flip = 8'h55;
  always @(posedge sys_clk) flip <= ~flip;
  always_comb begin
    p1_in = (p1_out & ~p1_oe_n) | (ext1 & p1_oe_n);
    p2_in = (p2_out & ~p2_oe_n) | (p2_oe_n & ((ext2 & ext2_en)
      | (~ext2_en & (p2_pu | flip))));
  end
endmodule : dog_pin_model

// *** testbench/tb_top.sv ***
/*
 Self-checking bench for dog_ports over AXI4-Lite.
 Assumes register byte address is four times the index.
*/
`timescale 1ns/10ps
module tb_top
  import dog_pkg::*;
;
  localparam logic [31:0] AD1 = {14'h0, DOG_IDX_P1_DIR, 2'h0};
  localparam logic [31:0] AD2 = {14'h0, DOG_IDX_P2_DIR, 2'h0};
  localparam logic [31:0] AP1 = {14'h0, DOG_IDX_P1_DAT, 2'h0};
  localparam logic [31:0] AP2 = {14'h0, DOG_IDX_P2_DAT, 2'h0};
  localparam logic [31:0] APU = {14'h0, DOG_IDX_P2_PUP, 2'h0};
  localparam logic [31:0] ACT = {14'h0, DOG_IDX_CTRL, 2'h0};
  logic sys_clk = 1'h0, resetn = 1'h0, hw_standby = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sw_standby_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode_out;
  logic [15:0] cpu_addr = 16'h5a3c;
  logic [7:0] port1_in, port1_out, port1_oe_n, port2_in, port2_out, port2_oe_n;
  logic [7:0] port2_pullup_on, ext1 = 8'h3c, ext2 = 8'h3c, ext2_en = 8'h0f;
  int errors = 0;
  int comparisons = 0;
  dog_ports dut (.sys_clk(sys_clk), .resetn(resetn), .hw_standby(hw_standby),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_addr(cpu_addr),
    .port1_in(port1_in), .port1_out(port1_out), .port1_oe_n(port1_oe_n), .port2_in(port2_in),
    .port2_out(port2_out), .port2_oe_n(port2_oe_n), .port2_pullup_on(port2_pullup_on),
    .mode_out(mode_out), .sw_standby_out(sw_standby_out));
  dog_pin_model u_pins (.sys_clk(sys_clk), .p1_out(port1_out), .p1_oe_n(port1_oe_n),
    .p2_out(port2_out), .p2_oe_n(port2_oe_n), .p2_pu(port2_pullup_on), .ext1(ext1),
    .ext2(ext2), .ext2_en(ext2_en), .p1_in(port1_in), .p2_in(port2_in));
  initial forever #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Extra leading edge so back-to-back calls never drive a signal twice in one step
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [7:0] ed);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
    chk({s_axi_rresp, s_axi_rdata}, {DOG_RESP_OKAY, 24'h0, ed});
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wr(ACT, 8'h01);
    settle;
    chk({port1_oe_n, port2_oe_n}, 16'hffff);
    chk(port2_pullup_on, 8'h00);
    rd(AD1, 8'hff);
    rd(AP1, 8'h3c);
    wr(32'h3ff40, 8'h55, DOG_RESP_SLVERR);
    wr(ACT, 8'h02);
  endtask : t_reset
  task automatic t_gpio;
    wr(AD1, 8'h0f);
    @(posedge sys_clk);
    chk(port1_oe_n, 8'hf0);
    wr(AP1, 8'ha5);
    wr(AD2, 8'h0f);
    wr(AP2, 8'h96);
    wr(APU, 8'hff);
    settle;
    chk({port1_out[3:0], port2_out[3:0]}, 8'h56);
    chk(port2_pullup_on, 8'hf0);
    rd(AP1, 8'h35);
    rd(AP2, 8'hf6);
    rd(AD2, 8'hff);
    rd(APU, 8'hff);
    // Low byte strobe off: answered OKAY, register untouched
    s_axi_wstrb <= 4'h0;
    wr(APU, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd(APU, 8'hff);
  endtask : t_gpio
  task automatic t_modes;
    for (int i = 0; i < 2; i++) begin
      wr(ACT, i ? 8'h01 : 8'h03);
      settle;
      chk({port1_out[3:0], port2_out[3:0]}, i ? 8'hca : 8'h56);
      chk(port1_oe_n, 8'hf0);
    end
  endtask : t_modes
  task automatic t_swstby;
    wr(ACT, 8'h05);
    settle;
    cpu_addr <= 16'h0000;
    settle;
    chk({port1_out[3:0], port2_out[3:0]}, 8'hca);
    chk({port2_oe_n, port2_pullup_on}, 16'hf0f0);
    rd(APU, 8'hff);
    rd(AP1, 8'h35);
    wr(ACT, 8'h01);
    settle;
    chk({port1_out[3:0], port2_out[3:0]}, 8'h00);
  endtask : t_swstby
  task automatic t_hwstby;
    ext2_en <= 8'hff;
    hw_standby <= 1'h1;
    repeat (2) @(posedge sys_clk);
    hw_standby <= 1'h0;
    settle;
    chk({port1_oe_n, port2_pullup_on}, 16'hff00);
    rd(APU, 8'h00);
    rd(AP2, 8'h3c);
    rd(ACT, 8'h01);
  endtask : t_hwstby
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    t_reset;
    t_gpio;
    t_modes;
    t_swstby;
    t_hwstby;
    final_report;
  end
  // Whole run needs about 125 cycles
  initial begin
    #100000;
    errors++;
    final_report;
  end
endmodule : tb_top
